// >>> design/ext_bus_area.sv
// Purpose: external bus cycles for areas 0 to 2 with lane steering and splitting
// Assumes: one request at a time, taken when req_valid and req_ready are high
// Notes:   pins are registered from the next state, so they line up with state_r
`timescale 1ns/1ps
module ext_bus_area #(
	parameter int COL_BITS = ext_bus_pkg::COL_BITS
) (
	input  logic        clk_sys,
	input  logic        rstn,
	input  logic        req_valid,
	input  logic        req_write,
	input  logic [28:0] req_addr,
	input  logic [1:0]  req_size,
	input  logic [63:0] req_wdata,
	output logic        req_ready,
	output logic        resp_valid,
	output logic        resp_error,
	output logic [63:0] resp_rdata,
	input  logic        width_mode_pin_hi,
	input  logic        width_mode_pin_lo,
	input  logic [2:0]  area0_type,
	input  logic [2:0]  area1_type,
	input  logic [2:0]  area2_type,
	input  logic [2:0]  area0_wait_count,
	input  logic [2:0]  area1_wait_count,
	input  logic [2:0]  area2_wait_count,
	input  logic        area0_setup_sel,
	input  logic        area1_setup_sel,
	input  logic        area2_setup_sel,
	input  logic [1:0]  area0_hold_sel,
	input  logic [1:0]  area1_hold_sel,
	input  logic [1:0]  area2_hold_sel,
	input  logic [1:0]  area1_width_sel,
	input  logic [1:0]  area2_width_sel,
	input  logic [1:0]  dram_width_bits,
	input  logic        ext_ready_n,
	input  logic [63:0] data_in,
	output logic [63:0] data_out,
	output logic        data_oe,
	output logic [28:0] ext_addr,
	output logic        area0_chip_select_n,
	output logic        area1_chip_select_n,
	output logic        area2_chip_select_n,
	output logic        read_strobe_n,
	output logic [7:0]  lane_write_strobe_n,
	output logic        row_strobe_n,
	output logic        col_strobe_n,
	output logic        rd_wr_dir,
	output logic [7:0]  byte_mask,
	output logic        muxed_addr_data_bus
);
	// ****************************************
	// request context
	// ****************************************
	ext_bus_pkg::state_type    state_r, state_nxt;
	ext_bus_pkg::mem_type_type mtype;
	logic [2:0]  area_r, cur_area, beat_r, beat_nxt, wcode, off;
	logic [1:0]  size_r, cur_size, lw, bsz, hold_n, boot_lw;
	logic [28:0] addr_r, cur_addr, baddr;
	logic [63:0] wdata_r, cur_wdata, rdata_r, bwdata;
	logic        write_r, cur_write, err_r, idle, hit, setup_en, dram_like, muxed;
	logic        burst_rd, last, next_beat, tload, tzero, acc_end, ready_r;
	logic [3:0]  nbeats, bytes, wval, bval, acc_cur, acc_next, tval;
	logic [7:0]  bmask, lanes;
	logic [5:0]  bshift_r, bshift_n;

	// byte mask to bit mask
	function automatic logic [63:0] expand(input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			expand[i*8 +: 8] = {8{m[i]}};
		end
	endfunction

	// while idle the request ports describe the cycle about to start
	assign idle      = (state_r == ext_bus_pkg::ST_IDLE);
	assign cur_area  = idle ? req_addr[ext_bus_pkg::AREA_MSB:ext_bus_pkg::AREA_LSB] : area_r;
	assign cur_size  = idle ? req_size : size_r;
	assign cur_addr  = idle ? req_addr : addr_r;
	assign cur_write = idle ? req_write : write_r;
	assign cur_wdata = idle ? req_wdata : wdata_r;

	width_latch u_width (
		.clk_sys           (clk_sys),
		.rstn              (rstn),
		.width_mode_pin_hi (width_mode_pin_hi),
		.width_mode_pin_lo (width_mode_pin_lo),
		.boot_lw           (boot_lw)
	);

	// per-area settings and legality of the memory type
	always_comb begin
		mtype    = ext_bus_pkg::MEM_SRAM;
		wcode    = 3'h0;
		setup_en = 1'b0;
		hold_n   = 2'h0;
		lw       = 2'h0;
		hit      = 1'b0;
		case (cur_area)
			ext_bus_pkg::AREA0_CODE: begin
				mtype    = ext_bus_pkg::mem_type_type'(area0_type);
				wcode    = area0_wait_count;
				setup_en = area0_setup_sel;
				hold_n   = area0_hold_sel;
				lw       = boot_lw;
				hit      = mtype inside {ext_bus_pkg::MEM_SRAM, ext_bus_pkg::MEM_MUXED, ext_bus_pkg::MEM_BURST_ROM};
			end
			ext_bus_pkg::AREA1_CODE: begin
				mtype    = ext_bus_pkg::mem_type_type'(area1_type);
				wcode    = area1_wait_count;
				setup_en = area1_setup_sel;
				hold_n   = area1_hold_sel;
				lw       = ext_bus_pkg::width_log2(area1_width_sel);
				hit      = mtype inside {ext_bus_pkg::MEM_SRAM, ext_bus_pkg::MEM_MUXED, ext_bus_pkg::MEM_BYTE_SRAM};
			end
			ext_bus_pkg::AREA2_CODE: begin
				mtype    = ext_bus_pkg::mem_type_type'(area2_type);
				wcode    = area2_wait_count;
				setup_en = area2_setup_sel;
				hold_n   = area2_hold_sel;
				hit      = mtype inside {ext_bus_pkg::MEM_SRAM, ext_bus_pkg::MEM_MUXED,
				                         ext_bus_pkg::MEM_DRAM, ext_bus_pkg::MEM_SDRAM};
				if (mtype inside {ext_bus_pkg::MEM_DRAM, ext_bus_pkg::MEM_SDRAM}) begin
					lw = ext_bus_pkg::width_log2(dram_width_bits);
				end else begin
					lw = ext_bus_pkg::width_log2(area2_width_sel);
				end
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	assign dram_like = (cur_area == ext_bus_pkg::AREA2_CODE) &&
	                   (mtype inside {ext_bus_pkg::MEM_DRAM, ext_bus_pkg::MEM_SDRAM});
	assign muxed     = (mtype == ext_bus_pkg::MEM_MUXED);
	assign burst_rd  = (mtype == ext_bus_pkg::MEM_BURST_ROM) && !cur_write;

	// lane offset inside a device word
	// narrow device splits by its width
	assign bsz      = (cur_size < lw) ? cur_size : lw;
	assign off      = (cur_size < lw) ? (cur_addr[2:0] & 3'((4'h1 << lw) - 4'h1)) : 3'h0;
	assign nbeats   = (cur_size > lw) ? (4'h1 << (cur_size - lw)) : 4'h1;
	assign bytes    = 4'h1 << bsz;
	assign bmask    = 8'((16'h1 << bytes) - 16'h1);
	assign lanes    = 8'(bmask << off);
	assign last     = (beat_r == 3'(nbeats - 4'h1));
	assign bshift_r = 6'({beat_r, 3'h0} << lw);
	assign bshift_n = 6'({beat_nxt, 3'h0} << lw);
	assign baddr    = 29'(cur_addr + (29'(beat_nxt) << lw));
	assign bwdata   = 64'(64'(cur_wdata >> bshift_n) << {off, 3'h0});

	assign wval     = ext_bus_pkg::WAIT_TABLE[wcode];
	// burst beat lasts code plus two states
	assign bval     = 4'(ext_bus_pkg::BURST_BASE + {1'b0, wcode} - 4'h1);
	assign acc_cur  = (burst_rd && beat_r != 3'h0) ? bval : wval;
	assign acc_next = burst_rd ? bval : wval;
	assign acc_end  = (state_r == ext_bus_pkg::ST_ACCESS) && tzero && !ext_ready_n;

	wait_timer #(.W(4)) u_timer (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.load     (tload),
		.load_val (tval),
		.zero     (tzero)
	);

	// ****************************************
	// cycle sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		beat_nxt  = beat_r;
		tload     = 1'b0;
		tval      = 4'h0;
		next_beat = 1'b0;
		case (state_r)
			ext_bus_pkg::ST_IDLE: begin
				if (req_valid && ready_r) begin
					beat_nxt = 3'h0;
					tload    = 1'b1;
					if (!hit) begin
						state_nxt = ext_bus_pkg::ST_DONE;
					end else if (setup_en || dram_like) begin
						state_nxt = ext_bus_pkg::ST_SETUP;
					end else begin
						state_nxt = ext_bus_pkg::ST_ACCESS;
						tval      = wval;
					end
				end
			end
			ext_bus_pkg::ST_SETUP: begin
				if (tzero) begin
					state_nxt = ext_bus_pkg::ST_ACCESS;
					tload     = 1'b1;
					tval      = acc_cur;
				end
			end
			ext_bus_pkg::ST_ACCESS: begin
				if (acc_end) begin
					if (hold_n != 2'h0 && !(burst_rd && !last)) begin
						state_nxt = ext_bus_pkg::ST_HOLD;
						tload     = 1'b1;
						tval      = 4'({2'h0, hold_n} - 4'h1);
					end else if (last) begin
						state_nxt = ext_bus_pkg::ST_DONE;
					end else begin
						next_beat = 1'b1;
					end
				end
			end
			ext_bus_pkg::ST_HOLD: begin
				if (tzero) begin
					if (last) begin
						state_nxt = ext_bus_pkg::ST_DONE;
					end else begin
						next_beat = 1'b1;
					end
				end
			end
			ext_bus_pkg::ST_DONE: begin
				state_nxt = ext_bus_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = ext_bus_pkg::ST_IDLE;
			end
		endcase
		// next split cycle follows at once
		if (next_beat) begin
			beat_nxt = beat_r + 3'h1;
			tload    = 1'b1;
			if ((setup_en || dram_like) && !burst_rd) begin
				state_nxt = ext_bus_pkg::ST_SETUP;
			end else begin
				state_nxt = ext_bus_pkg::ST_ACCESS;
				tval      = acc_next;
			end
		end
	end

	// state and beat registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= ext_bus_pkg::ST_IDLE;
			beat_r  <= 3'h0;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			beat_r  <= beat_nxt;
			ready_r <= (state_nxt == ext_bus_pkg::ST_IDLE);
		end
	end

	// request capture and read data assembly
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			area_r  <= 3'h0;
			size_r  <= 2'h0;
			addr_r  <= 29'h0;
			write_r <= 1'b0;
			wdata_r <= 64'h0;
			rdata_r <= 64'h0;
			err_r   <= 1'b0;
		end else if (idle && req_valid && ready_r) begin
			area_r  <= cur_area;
			size_r  <= req_size;
			addr_r  <= req_addr;
			write_r <= req_write;
			wdata_r <= req_wdata;
			rdata_r <= 64'h0;
			err_r   <= !hit;
		end else if (acc_end && !write_r) begin
			rdata_r <= rdata_r | (((data_in >> {off, 3'h0}) & expand(bmask)) << bshift_r);
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			area0_chip_select_n <= 1'b1;
			area1_chip_select_n <= 1'b1;
			area2_chip_select_n <= 1'b1;
			read_strobe_n       <= 1'b1;
			lane_write_strobe_n <= 8'hFF;
			row_strobe_n        <= 1'b1;
			col_strobe_n        <= 1'b1;
			rd_wr_dir           <= 1'b1;
			byte_mask           <= 8'hFF;
			ext_addr            <= 29'h0;
			data_out            <= 64'h0;
			data_oe             <= 1'b0;
			muxed_addr_data_bus <= 1'b0;
			resp_valid          <= 1'b0;
		end else begin
			// select held through setup, strobe and hold
			area0_chip_select_n <= !(hit && cur_area == ext_bus_pkg::AREA0_CODE &&
			                         state_nxt inside {ext_bus_pkg::ST_SETUP, ext_bus_pkg::ST_ACCESS, ext_bus_pkg::ST_HOLD});
			area1_chip_select_n <= !(hit && cur_area == ext_bus_pkg::AREA1_CODE &&
			                         state_nxt inside {ext_bus_pkg::ST_SETUP, ext_bus_pkg::ST_ACCESS, ext_bus_pkg::ST_HOLD});
			area2_chip_select_n <= !(hit && cur_area == ext_bus_pkg::AREA2_CODE &&
			                         state_nxt inside {ext_bus_pkg::ST_SETUP, ext_bus_pkg::ST_ACCESS, ext_bus_pkg::ST_HOLD});
			// static strobes only for non-DRAM types
			read_strobe_n       <= !(state_nxt == ext_bus_pkg::ST_ACCESS && !cur_write && !dram_like);
			// byte-control SRAM also wants lane selects on reads
			lane_write_strobe_n <= (state_nxt == ext_bus_pkg::ST_ACCESS && !dram_like &&
			                        (cur_write || mtype == ext_bus_pkg::MEM_BYTE_SRAM)) ? ~lanes : 8'hFF;
			// row then column with address multiplexing
			row_strobe_n        <= !(dram_like && state_nxt inside {ext_bus_pkg::ST_SETUP, ext_bus_pkg::ST_ACCESS});
			col_strobe_n        <= !(dram_like && state_nxt == ext_bus_pkg::ST_ACCESS);
			byte_mask           <= (dram_like && state_nxt != ext_bus_pkg::ST_IDLE) ? ~lanes : 8'hFF;
			rd_wr_dir           <= !(cur_write && state_nxt != ext_bus_pkg::ST_IDLE);
			if (dram_like && state_nxt == ext_bus_pkg::ST_ACCESS) begin
				ext_addr <= baddr & 29'((30'h1 << COL_BITS) - 30'h1);
			end else if (dram_like) begin
				ext_addr <= 29'(baddr >> COL_BITS);
			end else begin
				ext_addr <= baddr;
			end
			// multiplexed bus carries the address during setup
			muxed_addr_data_bus <= muxed && state_nxt == ext_bus_pkg::ST_SETUP;
			data_out            <= (muxed && state_nxt == ext_bus_pkg::ST_SETUP) ? {35'h0, baddr} : bwdata;
			data_oe             <= hit && ((cur_write && state_nxt inside {ext_bus_pkg::ST_ACCESS, ext_bus_pkg::ST_HOLD}) ||
			                               (muxed && state_nxt == ext_bus_pkg::ST_SETUP));
			resp_valid          <= (state_nxt == ext_bus_pkg::ST_DONE);
		end
	end

	assign req_ready  = ready_r;
	assign resp_error = err_r;
	assign resp_rdata = rdata_r;

	// ****************************************
	// checks
	// ****************************************
	logic [4:0] phase_len_r;
	logic [3:0] starts_r, exp_beats_r;

	// helper counters for phase length and beat count
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			phase_len_r <= 5'h0;
			starts_r    <= 4'h0;
			exp_beats_r <= 4'h0;
		end else begin
			phase_len_r <= tload ? 5'h0 : (phase_len_r == 5'h1F ? phase_len_r : phase_len_r + 5'h1);
			if (idle && req_valid && ready_r) begin
				starts_r    <= (state_nxt == ext_bus_pkg::ST_ACCESS) ? 4'h1 : 4'h0;
				exp_beats_r <= hit ? nbeats : 4'h0;
			end else if (state_nxt == ext_bus_pkg::ST_ACCESS && tload) begin
				starts_r <= starts_r + 4'h1;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	lane8_only_a: assert property (state_r == ext_bus_pkg::ST_ACCESS && $past(lw) == 2'h0 |-> lane_write_strobe_n[7:1] == 7'h7F)
		else $error("8-bit device used a lane above 0");
	lane16_byte_a: assert property (state_r == ext_bus_pkg::ST_ACCESS && write_r && size_r == 2'h0 &&
	                                $past(lw) == 2'h1 && !dram_like |-> lane_write_strobe_n == (ext_addr[0] ? 8'hFD : 8'hFE))
		else $error("16-bit byte on wrong lane");
	split_count_a: assert property (resp_valid && !resp_error |-> starts_r == exp_beats_r)
		else $error("split access beat count wrong");
	area_select_a: assert property (state_r inside {ext_bus_pkg::ST_ACCESS} && !err_r |->
	                                {area2_chip_select_n, area1_chip_select_n, area0_chip_select_n} ==
	                                ~(3'h1 << area_r))
		else $error("chip select does not match area");
	wait_min_a: assert property (acc_end |-> phase_len_r >= {1'b0, acc_cur})
		else $error("strobe shorter than programmed waits");
	ext_wait_a: assert property (state_r == ext_bus_pkg::ST_ACCESS && ext_ready_n |=> state_r == ext_bus_pkg::ST_ACCESS)
		else $error("cycle ended while external wait held");
	burst_len_a: assert property (acc_end && burst_rd && beat_r != 3'h0 && !$past(ext_ready_n) |->
	                              phase_len_r == 5'({1'b0, wcode} + 4'h1))
		else $error("burst beat length wrong");
	hold_len_a: assert property (state_r == ext_bus_pkg::ST_HOLD && tzero |-> phase_len_r == 5'({3'h0, hold_n} - 5'h1))
		else $error("hold length wrong");
	setup_first_a: assert property ($rose(state_r == ext_bus_pkg::ST_ACCESS) && beat_r == 3'h0 && setup_en |->
	                                $past(state_r) == ext_bus_pkg::ST_SETUP)
		else $error("setup cycle skipped");
	busy_block_a: assert property (state_r != ext_bus_pkg::ST_IDLE |-> !req_ready)
		else $error("request accepted while busy");
	boot_width_a: assert property ($past(rstn) |-> $stable(boot_lw))
		else $error("area 0 width changed after reset");
	sdram_strobe_a: assert property (state_r == ext_bus_pkg::ST_ACCESS && dram_like |->
	                                 !col_strobe_n && !row_strobe_n && read_strobe_n)
		else $error("DRAM strobes wrong");

	quad8_c:  cover property (resp_valid && size_r == 2'h3 && exp_beats_r == 4'h8);
	quad16_c: cover property (resp_valid && size_r == 2'h3 && exp_beats_r == 4'h4);
	burst_c:  cover property (acc_end && burst_rd && beat_r == 3'h3);
	wait_c:   cover property (state_r == ext_bus_pkg::ST_ACCESS && tzero && ext_ready_n [*3]);
endmodule

// >>> include/ext_bus_pkg.sv
// Purpose: shared constants and types for the external bus area access block
// Assumes: areas 0 to 2 only, little-endian lane order
// Notes:   width selector encoding and wait table values are local choices
package ext_bus_pkg;
	// ****************************************
	// decode and encodings
	// ****************************************
	localparam int         AREA_MSB   = 28;
	localparam int         AREA_LSB   = 26;
	localparam logic [2:0] AREA0_CODE = 3'h0;
	localparam logic [2:0] AREA1_CODE = 3'h1;
	localparam logic [2:0] AREA2_CODE = 3'h2;
	localparam logic [1:0] WSEL_64    = 2'h0;
	localparam logic [1:0] WSEL_8     = 2'h1;
	localparam logic [1:0] WSEL_16    = 2'h2;
	localparam logic [1:0] WSEL_32    = 2'h3;
	localparam int         COL_BITS   = 10;
	// wait cycles per three-bit code, 0 to 15
	localparam logic [3:0] WAIT_TABLE [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h9, 4'hF};
	// burst beat length is code plus this many states
	localparam logic [3:0] BURST_BASE = 4'h2;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_ACCESS = 3'b010,
		ST_HOLD   = 3'b011,
		ST_DONE   = 3'b100
	} state_type;

	typedef enum logic [2:0] {
		MEM_SRAM      = 3'b000,
		MEM_MUXED     = 3'b001,
		MEM_BURST_ROM = 3'b010,
		MEM_BYTE_SRAM = 3'b011,
		MEM_DRAM      = 3'b100,
		MEM_SDRAM     = 3'b101
	} mem_type_type;

	// log2 of bytes per device word
	function automatic logic [1:0] width_log2(input logic [1:0] sel);
		case (sel)
			WSEL_8:  width_log2 = 2'h0;
			WSEL_16: width_log2 = 2'h1;
			WSEL_32: width_log2 = 2'h2;
			default: width_log2 = 2'h3;
		endcase
	endfunction
endpackage

// >>> design/wait_timer.sv
// Purpose: down counter that times one bus phase
// Assumes: load wins over counting
// Notes:   zero means the current phase cycle is its last
`timescale 1ns/1ps
module wait_timer #(
	parameter int W = 4
) (
	input  logic         clk_sys,
	input  logic         rstn,
	input  logic         load,
	input  logic [W-1:0] load_val,
	output logic         zero
);
	logic [W-1:0] cnt_r;

	// phase length is load_val plus one cycle
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign zero = (cnt_r == '0);
endmodule

// >>> design/width_latch.sv
// Purpose: hold the area 0 bus width taken from the mode pins
// Assumes: pins are stable while reset is low
// Notes:   the value changes only during reset
`timescale 1ns/1ps
module width_latch (
	input  logic       clk_sys,
	input  logic       rstn,
	input  logic       width_mode_pin_hi,
	input  logic       width_mode_pin_lo,
	output logic [1:0] boot_lw
);
	logic [1:0] lw_r;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lw_r <= ext_bus_pkg::width_log2({width_mode_pin_hi, width_mode_pin_lo});
		end
	end

	assign boot_lw = lw_r;
endmodule

// >>> sim/mem_model.sv
// Purpose: byte memory on the far side of the external bus
// Assumes: tb tells the device width of the current access
// Notes:   unselected reads see a changing pattern, not old data
`timescale 1ns/1ps
module mem_model (
	input  wire logic        clk_sys,
	input  wire logic [2:0]  cs_n,
	input  wire logic        read_strobe_n,
	input  wire logic [7:0]  lws_n,
	input  wire logic [28:0] ext_addr,
	input  wire logic [63:0] data_out,
	input  wire logic [3:0]  dev_bytes,
	input  wire logic [3:0]  stall,
	output logic      [63:0] data_in,
	output logic             ext_ready_n
);
	logic [7:0]  mem [0:4095];
	logic [4:0]  cnt_r = 5'h00;
	logic [7:0]  junk_r = 8'h5A;
	logic        act;
	logic [28:0] base;
	assign act = !(&cs_n) && (!read_strobe_n || lws_n != 8'hFF);
	assign base = ext_addr & ~29'(dev_bytes - 4'h1);
	// slow device: hold off ready for stall cycles of each strobe phase
	assign ext_ready_n = act && cnt_r < 5'(stall);
	// store lanes whose write strobe is low, every cycle it is low
	always_ff @(posedge clk_sys) begin
		cnt_r <= act ? cnt_r + 5'h01 : 5'h00;
		junk_r <= junk_r + 8'h3B;
		for (int i = 0; i < 8; i++)
			if (act && !lws_n[i])
				mem[12'(base + 29'(i))] <= data_out[8*i +: 8];
	end
	// only read-enabled lanes of the device width carry memory bytes
	always_comb begin
		for (int i = 0; i < 8; i++)
			data_in[8*i +: 8] = (act && !read_strobe_n && i < dev_bytes) ? mem[12'(base + 29'(i))] : ~junk_r;
	end
endmodule

// >>> sim/ext_bus_area_tb.sv
// Purpose: random and corner traffic through the area access block
// Assumes: area 0 strapped to 16 bits, SRAM or muxed type in normal traffic
// Notes:   cycle counts run from the accept edge to the response
`timescale 1ns/1ps
module ext_bus_area_tb;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [28:0] req_addr = 29'h0;
	logic [1:0]  req_size = 2'h0;
	logic [63:0] req_wdata = 64'h0;
	logic [2:0]  typ [0:2] = '{3'h0, 3'h0, 3'h0};
	logic [2:0]  wc [0:2] = '{3'h0, 3'h0, 3'h0};
	logic        su [0:2] = '{1'b0, 1'b0, 1'b0};
	logic [1:0]  hd [0:2] = '{2'h0, 2'h0, 2'h0};
	logic [1:0]  ws [0:2] = '{2'h0, 2'h0, 2'h0};
	logic [1:0]  dram_w = 2'h0;
	logic [3:0]  dev_bytes = 4'h2;
	logic [3:0]  stall = 4'h0;
	logic        req_ready, resp_valid, resp_error, ext_ready_n, read_strobe_n;
	logic [2:0]  cs_n;
	logic        data_oe, rd_wr_dir, muxed_on;
	logic [7:0]  lws_n;
	logic [28:0] ext_addr;
	logic [63:0] resp_rdata, data_in, data_out;
	int          err_total = 0;
	int          comparisons = 0;

	always #50 clk_sys = ~clk_sys;

	ext_bus_area dut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_size(req_size), .req_wdata(req_wdata), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_error(resp_error), .resp_rdata(resp_rdata),
		.width_mode_pin_hi(1'b1), .width_mode_pin_lo(1'b0), .area0_type(typ[0]), .area1_type(typ[1]),
		.area2_type(typ[2]), .area0_wait_count(wc[0]), .area1_wait_count(wc[1]), .area2_wait_count(wc[2]),
		.area0_setup_sel(su[0]), .area1_setup_sel(su[1]), .area2_setup_sel(su[2]), .area0_hold_sel(hd[0]),
		.area1_hold_sel(hd[1]), .area2_hold_sel(hd[2]), .area1_width_sel(ws[1]), .area2_width_sel(ws[2]),
		.dram_width_bits(dram_w), .ext_ready_n(ext_ready_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .ext_addr(ext_addr), .area0_chip_select_n(cs_n[0]), .area1_chip_select_n(cs_n[1]),
		.area2_chip_select_n(cs_n[2]), .read_strobe_n(read_strobe_n), .lane_write_strobe_n(lws_n),
		.row_strobe_n(), .col_strobe_n(), .rd_wr_dir(rd_wr_dir), .byte_mask(), .muxed_addr_data_bus(muxed_on));

	mem_model far (.clk_sys(clk_sys), .cs_n(cs_n), .read_strobe_n(read_strobe_n), .lws_n(lws_n),
		.ext_addr(ext_addr), .data_out(data_out), .dev_bytes(dev_bytes), .stall(stall),
		.data_in(data_in), .ext_ready_n(ext_ready_n));

	// ****************************************
	// checking and request tasks
	// ****************************************
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// every wait is bounded; running out is a mismatch
	task automatic tick(inout int n);
		@(negedge clk_sys);
		n++;
		if (n > 500) begin
			err_total++;
			report_and_stop();
		end
	endtask

	// one request; first strobe cycle's lanes and selects are captured
	task automatic run(output int cyc, output logic [7:0] ln, output logic [2:0] cs);
		int n;
		n = 0;
		ln = 8'hFF;
		cs = 3'h7;
		while (req_ready !== 1'b1)
			tick(n);
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		n = 1;
		while (resp_valid !== 1'b1) begin
			// data drive and direction follow the strobe phase
			if (lws_n !== 8'hFF || read_strobe_n === 1'b0)
				check(64'({data_oe, rd_wr_dir}), req_write ? 64'h2 : 64'h1);
			// muxed bus shows the beat address in setup
			if (muxed_on === 1'b1)
				check(64'(data_out[28:0]), 64'(ext_addr));
			if (ln === 8'hFF && (req_write ? lws_n !== 8'hFF : read_strobe_n === 1'b0)) begin
				ln = lws_n;
				cs = cs_n;
			end
			tick(n);
		end
		cyc = n;
	endtask

	// setup, strobe phase stretched by waits or by the device, hold; per beat
	function automatic int exp_cycles(input logic [2:0] a, input logic [1:0] sc, input int dev);
		int beats, acc;
		beats = (1 << sc) > dev ? (1 << sc) / dev : 1;
		acc = ext_bus_pkg::WAIT_TABLE[wc[a]] + 1;
		if (stall + 1 > acc)
			acc = stall + 1;
		return 1 + beats * (su[a] + acc + hd[a]);
	endfunction

	function automatic logic [7:0] exp_lanes(input logic [28:0] ad, input logic [1:0] sc, input int dev);
		int n;
		n = (1 << sc) < dev ? (1 << sc) : dev;
		return ~(8'((1 << n) - 1) << (ad % dev));
	endfunction

	// write then read back one random aligned unit in area a
	task automatic rw(input logic [2:0] a, input logic [1:0] sc);
		int cyc, dev;
		logic [7:0] ln;
		logic [2:0] cs;
		dev = a == 3'h0 ? 2 : (ws[a] == 2'h0 ? 8 : 1 << (ws[a] - 2'h1));
		dev_bytes = 4'(dev);
		req_size = sc;
		req_addr = {a, 14'h0, 12'($urandom)} & ~29'((1 << sc) - 1);
		req_wdata = {$urandom, $urandom};
		for (int w = 1; w >= 0; w--) begin
			req_write = 1'(w);
			run(cyc, ln, cs);
			check(64'(cyc), 64'(exp_cycles(a, sc, dev)));
			check(64'(cs), 64'(3'h7 ^ (3'h1 << a)));
			check(64'(ln), 64'(w ? exp_lanes(req_addr, sc, dev) : 8'hFF));
			check(64'(resp_error), 64'h0);
		end
		check(resp_rdata, req_wdata & ((64'h1 << (8 << sc)) - 64'h1));
	endtask

	initial begin
		int cyc;
		logic [7:0] ln;
		logic [2:0] cs;
		void'($urandom(98));
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		// random timing and widths, every size in every area
		for (int k = 0; k < 48; k++) begin
			for (int i = 0; i < 3; i++) begin
				wc[i] = 3'($urandom);
				su[i] = 1'($urandom);
				hd[i] = 2'($urandom);
				ws[i] = 2'($urandom);
				// plain or muxed bus, both legal in every area
				typ[i] = ($urandom % 2) ? 3'h1 : 3'h0;
			end
			dram_w = 2'($urandom);
			rw(3'(k % 3), 2'(k / 3));
		end
		// slow device on an eight-beat split: each beat waits for ready
		su[1] = 1'b1;
		wc[1] = 3'h0;
		ws[1] = 2'h1;
		stall = 4'h5;
		rw(3'h1, 2'h3);
		stall = 4'h0;
		// reserved area, then an illegal type: error with no strobes
		req_addr = 29'h0C000000;
		run(cyc, ln, cs);
		check(64'(resp_error), 64'h1);
		check(64'(ln), 64'hFF);
		typ[0] = 3'h3;
		req_addr = 29'h0;
		run(cyc, ln, cs);
		check(64'(resp_error), 64'h1);
		report_and_stop();
	end
endmodule
